// ==== common/sfp_pkg.sv ====
// Shared constants and types for the serial flash page-program block
package sfp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Command opcodes
  localparam logic [7:0] OPC_PAGE_PROGRAM    = 8'h02;
  localparam logic [7:0] OPC_PAGE_PROGRAM_4B = 8'h12;
  localparam logic [7:0] OPC_WRITE_ENABLE    = 8'h06;
  localparam logic [7:0] OPC_READ_STATUS1    = 8'h05;

  ////////////////////////////////////////////////////////////////////////////
  // Array geometry
  localparam int         UNIT_BITS      = 128;
  localparam int         CODE_BITS      = 8;
  localparam int         MEM_UNITS      = 256;
  localparam int         PAGE_UNITS_MAX = 32;
  localparam logic [7:0] LAST_UNIT      = 8'hFF;
  localparam logic [4:0] LAST_U_SMALL   = 5'h0F;
  localparam logic [4:0] LAST_U_LARGE   = 5'h1F;
  localparam logic [7:0] FLIP_CODE_BASE = 8'h80;
  localparam logic [7:0] FLIP_LIMIT     = 8'h88;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] REG_STATUS   = 8'h00;
  localparam logic [7:0] REG_CFG2     = 8'h04;
  localparam logic [7:0] REG_CFG3     = 8'h08;
  localparam logic [7:0] REG_CTRL     = 8'h0C;
  localparam logic [7:0] REG_UNIT_SEL = 8'h10;
  localparam logic [7:0] REG_ECC_STAT = 8'h14;
  localparam logic [7:0] REG_ARRAY    = 8'h18;
  localparam logic [7:0] REG_FLIP     = 8'h1C;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int STS_WIP      = 0;
  localparam int STS_WEL      = 1;
  localparam int STS_PERR     = 6;
  localparam int CFG2_QUAD    = 6;
  localparam int CFG2_ADDR4   = 7;
  localparam int CFG3_PAGE512 = 4;
  localparam int CTRL_ERASE   = 0;
  localparam int CTRL_PROTECT = 1;
  localparam int ESTAT_ON     = 0;
  localparam int ESTAT_DFIX   = 1;
  localparam int ESTAT_CFIX   = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } sfp_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } sfp_axi_rsp_t;

  typedef struct packed {
    logic       sck;
    logic       cs_n;
    logic [3:0] io;
  } sfp_spi_in_t;

  typedef struct packed {
    logic [3:0] io;
    logic [3:0] oe;
  } sfp_spi_out_t;

  // One correction unit: data, hidden code and its bookkeeping
  typedef struct packed {
    logic                 programmed;
    logic                 ecc_on;
    logic                 err_data;
    logic                 err_code;
    logic [CODE_BITS-1:0] code;
    logic [UNIT_BITS-1:0] data;
  } sfp_unit_t;

  localparam sfp_unit_t ERASED_UNIT = '{1'b0, 1'b1, 1'b0, 1'b0, 8'h00, {UNIT_BITS{1'b1}}};

  typedef enum logic [2:0] {PH_CMD, PH_ADDR, PH_DATA, PH_STAT, PH_SKIP} sfp_phase_t;
  typedef enum logic [1:0] {ST_ERASE, ST_IDLE, ST_PROG} sfp_walk_t;

endpackage : sfp_pkg

// ==== dv/sfp_page_program_assertions.sv ====
// Port-level checks for the page-program block
`timescale 1ns/1ps
module sfp_chk
  import sfp_pkg::*;
(
  // Clock, reset and watched ports
  input wire logic         I_MCLK,
  input wire logic         I_ARST_N,
  input wire sfp_spi_in_t  I_SPI,
  input wire sfp_spi_out_t O_SPI,
  input wire sfp_axi_req_t I_AXI,
  input wire sfp_axi_rsp_t O_AXI
);
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (!I_ARST_N);
  // Both write beats taken in one edge
  sequence s_wr_taken;
    I_AXI.awvalid && O_AXI.awready && I_AXI.wvalid && O_AXI.wready;
  endsequence
  a_wr_answer: assert property (s_wr_taken |-> ##[1:2] O_AXI.bvalid)
    else $error("write not answered");
  a_b_holds: assert property (O_AXI.bvalid && !I_AXI.bready |=> O_AXI.bvalid && $stable(O_AXI.bresp))
    else $error("write answer dropped");
  a_r_answer: assert property (I_AXI.arvalid && O_AXI.arready |=> O_AXI.rvalid)
    else $error("read not answered");
  a_r_holds: assert property (O_AXI.rvalid && !I_AXI.rready |=> O_AXI.rvalid && $stable(O_AXI.rdata))
    else $error("read answer dropped");
  a_r_blocks: assert property (O_AXI.rvalid |-> !O_AXI.arready)
    else $error("read taken while busy");
  a_bad_addr: assert property (I_AXI.arvalid && O_AXI.arready && I_AXI.araddr > 8'h1C |=> O_AXI.rresp == RESP_SLVERR && O_AXI.rdata == 32'h0)
    else $error("unmapped read accepted");
  a_oe_shape: assert property (O_SPI.oe == 4'h0 || O_SPI.oe == 4'h2 || O_SPI.oe == 4'hF)
    else $error("odd pin enables");
  a_oe_quiet: assert property (I_SPI.cs_n [*8] |-> O_SPI.oe == 4'h0)
    else $error("pins driven while deselected");
endmodule : sfp_chk
bind sfp_page_program sfp_chk u_chk (.I_MCLK, .I_ARST_N, .I_SPI, .O_SPI, .I_AXI, .O_AXI);

// ==== dv/sfp_spi_host.sv ====
// SPI host controller model that frames flash commands
`timescale 1ns/1ps
module sfp_spi_host
  import sfp_pkg::*;
(
  // Clock and flash pins
  input  wire logic         i_clk,
  input  wire sfp_spi_out_t i_spo,
  output sfp_spi_in_t       o_spi
);
  // Bits seen on the device outputs; holds the last byte of a frame
  logic [7:0] rx;
  // Mode 0 idle: clock low, deselected
  initial o_spi = '{1'b0, 1'b1, 4'hA};
  // Whole bytes msb first, clock still outside frames
  task automatic frame(input logic [7:0] b[$], input bit quad);
    int s;
    s = quad ? 4 : 1;
    o_spi.cs_n <= 1'b0;
    foreach (b[k])
      for (int i = 8 - s; i >= 0; i -= s)
      begin
        o_spi.io <= quad ? b[k][i+:4] : {4{b[k][i]}};
        repeat (4) @(posedge i_clk);
        // Mode 0: take the device's bit at the rising clock
        rx <= quad ? {rx[3:0], i_spo.io} : {rx[6:0], i_spo.io[1]};
        o_spi.sck <= 1'b1;
        repeat (4) @(posedge i_clk);
        o_spi.sck <= 1'b0;
      end
    repeat (4) @(posedge i_clk);
    o_spi.cs_n <= 1'b1;
    o_spi.io   <= ~o_spi.io; // Released lines never show stale data
    repeat (4) @(posedge i_clk);
  endtask : frame
endmodule : sfp_spi_host

// ==== dv/testbench.sv ====
// Self-checking bench for the page-program block
`timescale 1ns/1ps
module testbench
  import sfp_pkg::*;
;
  logic         clk = 1'b0;
  logic         arst_n;
  sfp_axi_req_t req;
  sfp_axi_rsp_t rsp;
  sfp_spi_in_t  spi;
  sfp_spi_out_t spo;
  logic [31:0]  d;
  logic [1:0]   r;
  logic [7:0]   q[$];
  int           errors = 0;
  int           checks = 0;
  // 25 MHz clock
  always #20 clk = ~clk;
  `define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin errors++; $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
  sfp_page_program dut (.I_MCLK(clk), .I_ARST_N(arst_n), .I_SPI(spi), .O_SPI(spo), .I_AXI(req), .O_AXI(rsp));
  sfp_spi_host host (.i_clk(clk), .i_spo(spo), .o_spi(spi));
  task automatic results;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results
  // Bounded waits end the run as a failure
  task automatic tmo(input int n);
    if (n >= 200)
    begin
      errors++;
      results();
    end
  endtask : tmo
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{1'b1, a, 1'b1, v, 4'hF, 1'b1, 1'b0, 8'h00, 1'b0};
    do
    begin
      @(posedge clk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
      n++;
    end
    while (rsp.bvalid !== 1'b1 && n < 200);
    req.bready <= 1'b0;
    tmo(n);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{1'b0, 8'h00, 1'b0, 32'h0, 4'h0, 1'b0, 1'b1, a, 1'b1};
    do
    begin
      @(posedge clk);
      if (rsp.arready) req.arvalid <= 1'b0;
      n++;
    end
    while (rsp.rvalid !== 1'b1 && n < 200);
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
    tmo(n);
  endtask : rd
  // Poll until no operation runs
  task automatic idle;
    int n;
    n = 0;
    do
    begin
      rd(REG_STATUS);
      n++;
    end
    while (d[STS_WIP] !== 1'b0 && n < 200);
    tmo(n);
  endtask : idle
  task automatic peek(input logic [9:0] u, input logic [7:0] a);
    wr(REG_UNIT_SEL, {22'h0, u});
    rd(a);
  endtask : peek
  // Main sequence
  initial
  begin
    arst_n = 1'b0;
    req    = '0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    idle();
    rd(8'h40); `CHK("unmapped", RESP_SLVERR, r)
    q = {OPC_PAGE_PROGRAM, 8'h00, 8'h00, 8'h00};
    host.frame({q, 8'h00}, 0);
    idle();
    peek(10'h000, REG_ARRAY); `CHK("no write_enable_cmd", 32'hFFFFFFFF, d)
    wr(REG_CFG2, 32'h40);
    host.frame({OPC_WRITE_ENABLE}, 1);
    rd(REG_STATUS); `CHK("quad write_enable_cmd", 1'b1, d[STS_WEL])
    host.frame({OPC_READ_STATUS1, 8'h00}, 1);
    `CHK("quad sr", 8'h02, host.rx)
    wr(REG_CFG2, 32'h0);
    repeat (16) q.push_back(8'h5A);
    host.frame(q, 0);
    rd(REG_STATUS); `CHK("busy", 1'b1, d[STS_WIP])
    idle(); `CHK("wel", 1'b0, d[STS_WEL])
    peek(10'h000, REG_ARRAY); `CHK("word", 32'h5A5A5A5A, d)
    peek(10'h000, REG_ECC_STAT); `CHK("ecc on", 1'b1, d[ESTAT_ON])
    wr(REG_FLIP, 32'h3);
    peek(10'h000, REG_ARRAY); `CHK("fixed", 32'h5A5A5A5A, d)
    rd(REG_ECC_STAT); `CHK("dfix", 1'b1, d[ESTAT_DFIX])
    host.frame({OPC_WRITE_ENABLE}, 0);
    host.frame({OPC_PAGE_PROGRAM_4B, 8'h00, 8'h00, 8'h00, 8'h04, 8'hFF}, 0);
    idle();
    peek(10'h100, REG_ARRAY); `CHK("zeros", 32'h5A5A5A5A, d)
    rd(REG_ECC_STAT); `CHK("ecc off", 1'b0, d[ESTAT_ON])
    wr(REG_CTRL, 32'h2);
    host.frame({OPC_WRITE_ENABLE}, 0);
    host.frame(q, 0);
    rd(REG_STATUS); `CHK("perr", 1'b1, d[STS_PERR])
    host.frame({OPC_READ_STATUS1, 8'h00}, 0);
    `CHK("sr", 8'h40, host.rx)
    wr(REG_CTRL, 32'h1);
    idle();
    rd(REG_ECC_STAT); `CHK("ecc back", 3'h1, d[2:0])
    results();
  end
endmodule : testbench

// ==== src/sfp_ecc.sv ====
// Hamming single-error code generator and corrector for one 16-byte unit
`timescale 1ns/1ps
module sfp_ecc
  import sfp_pkg::*;
(
  // Unit contents
  input  wire logic [UNIT_BITS-1:0] i_data,
  input  wire logic [CODE_BITS-1:0] i_code,
  // Results
  output logic      [CODE_BITS-1:0] o_code,
  output logic      [UNIT_BITS-1:0] o_fixed,
  output logic                      o_err_data,
  output logic                      o_err_code
);

  logic [CODE_BITS-1:0] pos;
  logic [CODE_BITS-1:0] pos_r;
  logic [CODE_BITS-1:0] syn;
  logic [CODE_BITS-1:0] calc;

  ////////////////////////////////////////////////////////////////////////////
  // Code is the XOR of the positions of all set data bits; powers of two
  // are left to the check bits, so a lone check-bit flip shows as one bit
  always_comb
  begin
    pos  = 8'h03;
    calc = 8'h00;
    for (int i = 0; i < UNIT_BITS; i++)
    begin
      if ((pos & (pos - 8'h01)) == 8'h00)
        pos = pos + 8'h01;
      if (i_data[i])
        calc = calc ^ pos;
      pos = pos + 8'h01;
    end
    o_code = calc;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Syndrome decode: data position flips that bit, power of two is the code
  always_comb
  begin
    syn        = i_code ^ calc;
    pos_r      = 8'h03;
    o_fixed    = i_data;
    o_err_data = 1'b0;
    o_err_code = (syn != 8'h00) && ((syn & (syn - 8'h01)) == 8'h00);
    for (int i = 0; i < UNIT_BITS; i++)
    begin
      if ((pos_r & (pos_r - 8'h01)) == 8'h00)
        pos_r = pos_r + 8'h01;
      if (syn == pos_r)
      begin
        o_fixed[i] = ~i_data[i];
        o_err_data = 1'b1;
      end
      pos_r = pos_r + 8'h01;
    end
  end

endmodule : sfp_ecc

// ==== src/sfp_page_program.sv ====
// Serial flash page-program engine with per-unit correction and register port
// Behaviour
// - Every aligned 16-byte block carries a hidden correction code; together one unit.
// - First programming of a unit with all 16 bytes loaded computes and stores its code over the whole unit.
// - Reads of a programmed unit with correction on repair any single-bit data or code error.
// - Programming a unit again disables its correction until an erase.
// - Units with correction off return raw data with no detection or repair.
// - Per-unit status shows correction on, data error fixed, code error fixed.
// - Program page is 256 or 512 bytes, picked by a configuration bit.
// - Pages align to the page size; one program writes one byte up to a page.
// - A single byte may be programmed anywhere; its unit then loses correction.
// - Programming only turns ones into zeros; zeros stay zero.
// - Page program is accepted only after write enable has set the latch.
// - Opcode 02h takes 3 or 4 address bytes by config bit; 12h always 4.
// - Data past the page end wraps to byte zero of the same page.
// - Short data programs sequentially from the address; other page bytes unchanged.
// - Write-in-progress reads one while programming runs, zero when done.
// - Program error sets when a page program is refused because the protect bit is on.
// - In four-wire mode the command moves on all four lines, two clocks per byte.
// - Four-wire mode is selected by bit 6 of config register 2.
`timescale 1ns/1ps
module sfp_page_program
  import sfp_pkg::*;
(
  // Clock and reset
  input  wire logic         I_MCLK,
  input  wire logic         I_ARST_N,
  // Serial flash pins
  input  wire sfp_spi_in_t  I_SPI,
  output sfp_spi_out_t      O_SPI,
  // Register bus
  input  wire sfp_axi_req_t I_AXI,
  output sfp_axi_rsp_t      O_AXI
);

  ////////////////////////////////////////////////////////////////////////////
  // State of the block
  typedef struct packed {
    logic                      sck_m;
    logic                      sck_s;
    logic                      sck_p;
    logic                      cs_m;
    logic                      cs_s;
    logic                      cs_p;
    logic [3:0]                io_m;
    logic [3:0]                io_s;
    sfp_phase_t                phase;
    logic [2:0]                bcnt;
    logic [7:0]                shreg;
    logic [1:0]                acnt;
    logic [31:0]               addr;
    logic [8:0]                ptr;
    logic                      pg512;
    logic [7:0]                base;
    logic                      got_data;
    logic                      write_enable_cmd_seen;
    logic [2:0]                ocnt;
    logic [7:0]                obyte;
    sfp_walk_t                 st;
    logic [7:0]                u;
    logic [PAGE_UNITS_MAX*16-1:0] mask;
    logic                      write_enable_latch;
    logic                      perr;
    logic [7:0]                cfg2;
    logic [7:0]                cfg3;
    logic                      protect;
    logic [9:0]                unit_sel;
    logic [7:0]                awaddr;
    logic                      aw_got;
    logic [31:0]               wdata;
    logic [3:0]                wstrb;
    logic                      w_got;
    sfp_axi_rsp_t              rsp;
    sfp_spi_out_t              spo;
  } sfp_state_t;

  sfp_state_t           s_q;
  sfp_state_t           s_d;
  sfp_unit_t            mem [MEM_UNITS];
  logic [UNIT_BITS-1:0] pbuf [PAGE_UNITS_MAX];

  logic                 mem_we;
  logic [7:0]           mem_wi;
  sfp_unit_t            mem_wd;
  logic                 pb_we;
  logic [8:0]           pb_idx;
  logic [7:0]           pb_byte;

  logic                 sck_rise;
  logic                 sck_fall;
  logic                 cs_rise;
  logic                 quad;
  logic [7:0]           nbyte;
  logic [2:0]           nbc;
  logic [31:0]          addr_n;
  logic [7:0]           status;
  logic [7:0]           wi;
  sfp_unit_t            cur;
  logic [15:0]          umask;
  logic [UNIT_BITS-1:0] merged;
  logic [UNIT_BITS-1:0] new_data;
  logic [CODE_BITS-1:0] new_code;
  sfp_unit_t            rd_unit;
  logic [UNIT_BITS-1:0] rd_fixed;
  logic                 rd_edc;
  logic                 rd_err_d;
  logic                 rd_err_c;
  logic [UNIT_BITS-1:0] rd_data;
  logic [31:0]          wmask;

  ////////////////////////////////////////////////////////////////////////////
  // Pin edges, seen only after the two-stage synchronisers
  assign sck_rise = s_q.sck_s & ~s_q.sck_p;
  assign sck_fall = ~s_q.sck_s & s_q.sck_p;
  assign cs_rise  = s_q.cs_s & ~s_q.cs_p;
  assign quad     = s_q.cfg2[CFG2_QUAD];
  // Four bits per edge in four-wire mode, one on the serial input otherwise
  assign nbyte    = quad ? {s_q.shreg[3:0], s_q.io_s} : {s_q.shreg[6:0], s_q.io_s[0]};
  assign nbc      = s_q.bcnt + (quad ? 3'h4 : 3'h1);
  assign addr_n   = {s_q.addr[23:0], nbyte};
  assign status   = {1'b0, s_q.perr, 4'h0, s_q.write_enable_latch, s_q.st != ST_IDLE};
  assign wmask    = {{8{s_q.wstrb[3]}}, {8{s_q.wstrb[2]}}, {8{s_q.wstrb[1]}}, {8{s_q.wstrb[0]}}};

  ////////////////////////////////////////////////////////////////////////////
  // Program walk: one unit per cycle, buffer bytes ANDed into the stored ones
  assign wi    = s_q.base + s_q.u;
  assign cur   = mem[wi];
  assign umask = s_q.mask[s_q.u[4:0]*16 +: 16];

  genvar gb;
  generate
    for (gb = 0; gb < 16; gb++)
    begin : g_merge
      // Unloaded bytes stay unchanged because they AND with all ones
      assign merged[gb*8 +: 8] = umask[gb] ? pbuf[s_q.u[4:0]][gb*8 +: 8] : 8'hFF;
    end
  endgenerate

  assign new_data = cur.data & merged;

  sfp_ecc u_ecc_prog (
    .i_data     (new_data),
    .i_code     (cur.code),
    .o_code     (new_code),
    .o_fixed    (),
    .o_err_data (),
    .o_err_code ()
  );

  ////////////////////////////////////////////////////////////////////////////
  // Array read path for the register port
  assign rd_unit = mem[s_q.unit_sel[7:0]];
  assign rd_edc  = rd_unit.programmed & rd_unit.ecc_on;
  assign rd_data = rd_edc ? rd_fixed : rd_unit.data;

  sfp_ecc u_ecc_read (
    .i_data     (rd_unit.data),
    .i_code     (rd_unit.code),
    .o_code     (),
    .o_fixed    (rd_fixed),
    .o_err_data (rd_err_d),
    .o_err_code (rd_err_c)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb
  begin
    s_d     = s_q;
    mem_we  = 1'b0;
    mem_wi  = 8'h00;
    mem_wd  = cur;
    pb_we   = 1'b0;
    pb_idx  = s_q.ptr;
    pb_byte = nbyte;

    // Synchronisers
    s_d.sck_m = I_SPI.sck;
    s_d.sck_s = s_q.sck_m;
    s_d.sck_p = s_q.sck_s;
    s_d.cs_m  = I_SPI.cs_n;
    s_d.cs_s  = s_q.cs_m;
    s_d.cs_p  = s_q.cs_s;
    s_d.io_m  = I_SPI.io;
    s_d.io_s  = s_q.io_m;

    // Serial frame: idle while deselected, shift on rising, drive on falling
    if (s_q.cs_s)
    begin
      s_d.phase     = PH_CMD;
      s_d.bcnt      = 3'h0;
      s_d.write_enable_cmd_seen = 1'b0;
      s_d.got_data  = 1'b0;
      s_d.spo       = '0;
    end
    else if (sck_rise)
    begin
      s_d.shreg = nbyte;
      s_d.bcnt  = nbc;
      if (nbc == 3'h0)
      begin
        case (s_q.phase)
          PH_CMD:
          begin
            s_d.phase = PH_SKIP;
            if (nbyte == OPC_READ_STATUS1)
            begin
              s_d.phase = PH_STAT;
              s_d.ocnt  = 3'h0;
            end
            else if (s_q.st == ST_IDLE)
            begin
              if (nbyte == OPC_WRITE_ENABLE)
                s_d.write_enable_cmd_seen = 1'b1;
              else if ((nbyte == OPC_PAGE_PROGRAM || nbyte == OPC_PAGE_PROGRAM_4B) && s_q.write_enable_latch)
              begin
                s_d.phase    = PH_ADDR;
                s_d.acnt     = (nbyte == OPC_PAGE_PROGRAM_4B || s_q.cfg2[CFG2_ADDR4]) ?
                               2'h3 : 2'h2;
                s_d.mask     = '0;
                s_d.got_data = 1'b0;
              end
            end
          end
          PH_ADDR:
          begin
            s_d.addr = addr_n;
            s_d.acnt = s_q.acnt - 2'h1;
            if (s_q.acnt == 2'h0)
            begin
              // Page aligned on its own size; load starts at the given byte
              s_d.phase = PH_DATA;
              s_d.pg512 = s_q.cfg3[CFG3_PAGE512];
              s_d.ptr   = s_q.cfg3[CFG3_PAGE512] ? addr_n[8:0] : {1'b0, addr_n[7:0]};
              s_d.base  = s_q.cfg3[CFG3_PAGE512] ? {addr_n[11:9], 5'h00} :
                          {addr_n[11:8], 4'h0};
            end
          end
          PH_DATA:
          begin
            pb_we                = 1'b1;
            s_d.mask[s_q.ptr]    = 1'b1;
            s_d.got_data         = 1'b1;
            // Pointer wraps inside the page, later bytes overwrite earlier
            s_d.ptr = s_q.pg512 ? s_q.ptr + 9'h001 : {1'b0, s_q.ptr[7:0] + 8'h01};
          end
          PH_SKIP:
            s_d.write_enable_cmd_seen = 1'b0;
          default: ;
        endcase
      end
    end
    else if (sck_fall && s_q.phase == PH_STAT)
    begin
      // Status streams repeatedly, fresh copy at each byte start
      s_d.obyte = (s_q.ocnt == 3'h0) ? status : s_q.obyte;
      if (quad)
      begin
        s_d.spo.io = s_d.obyte[7:4];
        s_d.spo.oe = 4'hF;
        s_d.obyte  = {s_d.obyte[3:0], 4'h0};
        s_d.ocnt   = s_q.ocnt + 3'h4;
      end
      else
      begin
        s_d.spo.io = {2'b00, s_d.obyte[7], 1'b0};
        s_d.spo.oe = 4'h2;
        s_d.obyte  = {s_d.obyte[6:0], 1'b0};
        s_d.ocnt   = s_q.ocnt + 3'h1;
      end
    end

    // Register bus: address and data taken in either order
    if (I_AXI.awvalid && s_q.rsp.awready)
    begin
      s_d.awaddr = I_AXI.awaddr;
      s_d.aw_got = 1'b1;
    end
    if (I_AXI.wvalid && s_q.rsp.wready)
    begin
      s_d.wdata = I_AXI.wdata;
      s_d.wstrb = I_AXI.wstrb;
      s_d.w_got = 1'b1;
    end
    if (s_q.rsp.bvalid && I_AXI.bready)
      s_d.rsp.bvalid = 1'b0;
    if (s_q.aw_got && s_q.w_got && !s_q.rsp.bvalid)
    begin
      s_d.aw_got     = 1'b0;
      s_d.w_got      = 1'b0;
      s_d.rsp.bvalid = 1'b1;
      s_d.rsp.bresp  = RESP_OKAY;
      case ({s_q.awaddr[7:2], 2'b00})
        REG_STATUS:
          if (wmask[STS_PERR] && s_q.wdata[STS_PERR])
            s_d.perr = 1'b0;
        REG_CFG2:
          s_d.cfg2 = (s_q.cfg2 & ~wmask[7:0]) | (s_q.wdata[7:0] & wmask[7:0]);
        REG_CFG3:
          s_d.cfg3 = (s_q.cfg3 & ~wmask[7:0]) | (s_q.wdata[7:0] & wmask[7:0]);
        REG_CTRL:
          if (wmask[0])
          begin
            s_d.protect = s_q.wdata[CTRL_PROTECT];
            if (s_q.wdata[CTRL_ERASE] && s_q.st == ST_IDLE)
            begin
              s_d.st = ST_ERASE;
              s_d.u  = 8'h00;
            end
          end
        REG_UNIT_SEL:
          s_d.unit_sel = (s_q.unit_sel & ~wmask[9:0]) | (s_q.wdata[9:0] & wmask[9:0]);
        REG_FLIP:
          // Fault injection, only between operations
          if (wmask[0] && s_q.st == ST_IDLE && s_q.wdata[7:0] < FLIP_LIMIT)
          begin
            mem_we = 1'b1;
            mem_wi = s_q.unit_sel[7:0];
            mem_wd = rd_unit;
            if (s_q.wdata[7:0] < FLIP_CODE_BASE)
              mem_wd.data[s_q.wdata[6:0]] = ~rd_unit.data[s_q.wdata[6:0]];
            else
              mem_wd.code[s_q.wdata[2:0]] = ~rd_unit.code[s_q.wdata[2:0]];
          end
        REG_ECC_STAT, REG_ARRAY: ;
        default:
          s_d.rsp.bresp = RESP_SLVERR;
      endcase
    end

    // Register reads answer one cycle after the address is taken
    if (s_q.rsp.rvalid && I_AXI.rready)
      s_d.rsp.rvalid = 1'b0;
    if (I_AXI.arvalid && s_q.rsp.arready)
    begin
      s_d.rsp.rvalid = 1'b1;
      s_d.rsp.rresp  = RESP_OKAY;
      s_d.rsp.rdata  = 32'h0000_0000;
      case ({I_AXI.araddr[7:2], 2'b00})
        REG_STATUS:   s_d.rsp.rdata[7:0] = status;
        REG_CFG2:     s_d.rsp.rdata[7:0] = s_q.cfg2;
        REG_CFG3:     s_d.rsp.rdata[7:0] = s_q.cfg3;
        REG_CTRL:     s_d.rsp.rdata[CTRL_PROTECT] = s_q.protect;
        REG_UNIT_SEL: s_d.rsp.rdata[9:0] = s_q.unit_sel;
        REG_ECC_STAT:
        begin
          s_d.rsp.rdata[ESTAT_ON]   = rd_unit.ecc_on;
          s_d.rsp.rdata[ESTAT_DFIX] = rd_unit.err_data;
          s_d.rsp.rdata[ESTAT_CFIX] = rd_unit.err_code;
        end
        REG_ARRAY:
        begin
          s_d.rsp.rdata = rd_data[s_q.unit_sel[9:8]*32 +: 32];
          // Record a repair against the unit; skipped if the port is busy
          if (rd_edc && (rd_err_d || rd_err_c) && !mem_we && s_q.st == ST_IDLE)
          begin
            mem_we          = 1'b1;
            mem_wi          = s_q.unit_sel[7:0];
            mem_wd          = rd_unit;
            mem_wd.err_data = rd_unit.err_data | rd_err_d;
            mem_wd.err_code = rd_unit.err_code | rd_err_c;
          end
        end
        REG_FLIP: ;
        default:      s_d.rsp.rresp = RESP_SLVERR;
      endcase
    end

    // Chip-select release after whole bytes commits the command
    if (cs_rise && s_q.bcnt == 3'h0 && s_q.st == ST_IDLE)
    begin
      if (s_q.write_enable_cmd_seen)
        s_d.write_enable_latch = 1'b1;
      if (s_q.phase == PH_DATA && s_q.got_data)
      begin
        if (s_q.protect)
        begin
          s_d.perr = 1'b1;
          s_d.write_enable_latch  = 1'b0;
        end
        else
        begin
          s_d.st = ST_PROG;
          s_d.u  = 8'h00;
        end
      end
    end

    // Array walks; they own the array write port while busy
    case (s_q.st)
      ST_ERASE:
      begin
        mem_we = 1'b1;
        mem_wi = s_q.u;
        mem_wd = ERASED_UNIT;
        s_d.u  = s_q.u + 8'h01;
        if (s_q.u == LAST_UNIT)
          s_d.st = ST_IDLE;
      end
      ST_PROG:
      begin
        if (umask != 16'h0000)
        begin
          mem_we            = 1'b1;
          mem_wi            = wi;
          mem_wd            = cur;
          mem_wd.data       = new_data;
          mem_wd.programmed = 1'b1;
          if (!cur.programmed && (&umask))
          begin
            mem_wd.code     = new_code;
            mem_wd.err_data = 1'b0;
            mem_wd.err_code = 1'b0;
          end
          else
            mem_wd.ecc_on   = 1'b0;
        end
        s_d.u = s_q.u + 8'h01;
        if (s_q.u == {3'h0, s_q.pg512 ? LAST_U_LARGE : LAST_U_SMALL})
        begin
          s_d.st  = ST_IDLE;
          s_d.write_enable_latch = 1'b0;
        end
      end
      default: ;
    endcase

    // Readies follow the outstanding state so a taken beat is never lost
    s_d.rsp.arready = ~s_d.rsp.rvalid;
    s_d.rsp.awready = ~s_d.aw_got & ~s_d.rsp.bvalid;
    s_d.rsp.wready  = ~s_d.w_got & ~s_d.rsp.bvalid;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; reset lands in the erase walk so the array starts blank
  always_ff @(posedge I_MCLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      // Select stages start at the idle high level, so no false release
      s_q      <= '0;
      s_q.cs_m <= 1'b1;
      s_q.cs_s <= 1'b1;
      s_q.cs_p <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Array and page buffer, no reset on storage
  always_ff @(posedge I_MCLK)
  begin
    if (mem_we)
      mem[mem_wi] <= mem_wd;
    if (pb_we)
      pbuf[pb_idx[8:4]][{pb_idx[3:0], 3'b000} +: 8] <= pb_byte;
  end

  assign O_AXI = s_q.rsp;
  assign O_SPI = s_q.spo;

endmodule : sfp_page_program
